// ---- rtl/bcs_sequencer.sv ----
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns

// Summary of operation
// R01 - drivers off unless supply and enable good
// R02 - power-on-ready starts the soft-start ramp
// R03 - turn on only above enable threshold
// R04 - enable below shutdown threshold turns drivers off
// R05 - pre-bias: low side off until first high pulse
// R06 - low-side duty starts at eighth, steps eighths
// R07 - sixteen pulses per step, eight steps
// R08 - soft-start level rises linearly to top
// R09 - fault protection active during the ramp
// R10 - bias low at light load, else high
// R11 - over-current hiccup blanks, then retries soft-start
// R12 - over-temperature stops switching, restarts when cool
// R13 - analog side supplies single-bit monitor flags
// R14 - pulses counted on tick; stepping restarts
module bcs_sequencer #(
	parameter int HICCUP_CYC = bcs_pkg::HICCUP_CYC
) (
	// clock, reset, enable
	input  wire logic              i_ref_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_clk_en,
	// analog monitor flags
	input  wire bcs_pkg::bcs_mon_t i_mon,
	// axi4-lite write
	input  wire logic              i_s_axi_awvalid,
	output logic                   o_s_axi_awready,
	input  wire logic [7:0]        i_s_axi_awaddr,
	input  wire logic              i_s_axi_wvalid,
	output logic                   o_s_axi_wready,
	input  wire logic [31:0]       i_s_axi_wdata,
	input  wire logic [3:0]        i_s_axi_wstrb,
	output logic                   o_s_axi_bvalid,
	input  wire logic              i_s_axi_bready,
	output logic [1:0]             o_s_axi_bresp,
	// axi4-lite read
	input  wire logic              i_s_axi_arvalid,
	output logic                   o_s_axi_arready,
	input  wire logic [7:0]        i_s_axi_araddr,
	output logic                   o_s_axi_rvalid,
	input  wire logic              i_s_axi_rready,
	output logic [31:0]            o_s_axi_rdata,
	output logic [1:0]             o_s_axi_rresp,
	// driver and bias commands
	output logic                   o_hs_on,
	output logic                   o_ls_on,
	output logic                   o_bias_high,
	output logic                   o_por_ready,
	output logic [11:0]            o_ss_level,
	output logic                   o_irq
);

	// ----------------------------------------------------------------
	// monitor inputs
	// ----------------------------------------------------------------
	bcs_pkg::bcs_mon_t   mon_f;
	bcs_pkg::bcs_state_t state_q;
	logic [11:0]         level_q;
	logic [7:0]          div_q;
	logic [23:0]         hic_q;
	logic [15:0]         phase_q;
	logic [15:0]         period_q;
	logic                tick_d_q;
	logic                ot_d_q;
	logic                ov_d_q;
	logic                pb_active_q;
	logic                pb_wait_q;
	logic [3:0]          step_q;
	logic [4:0]          pulse_q;
	logic                ctrl_en_q;
	logic [4:0]          irq_stat_q;
	logic [4:0]          irq_mask_q;
	logic                por_w;
	logic                active_w;
	logic                hic_done_w;
	logic                start_w;
	logic                tick_w;
	logic [19:0]         ls_prod_w;
	logic [15:0]         ls_lim_w;
	logic                ls_win_w;
	logic [4:0]          irq_ev_w;

	// comparator outputs are asynchronous to the soft-start clock
	bcs_pin_sync #(
		.W        ($bits(bcs_pkg::bcs_mon_t))
	) u_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst_n  (i_rst_n),
		.i_clk_en (i_clk_en),
		.i_pin    (i_mon),
		.o_level  (mon_f)
	);

	// power-on-ready: supply, enable above threshold, not too hot
	assign por_w      = mon_f.vcc_ok && mon_f.en_ok && !mon_f.ot;     // R01 R02 R03 R04 R12
	assign active_w   = ((state_q == bcs_pkg::ST_RAMP) || (state_q == bcs_pkg::ST_RUN))
		&& por_w && !mon_f.oc;
	assign hic_done_w = (hic_q == 24'(HICCUP_CYC - 1));
	assign start_w    = por_w && (((state_q == bcs_pkg::ST_OFF) && ctrl_en_q)
		|| ((state_q == bcs_pkg::ST_HICCUP) && hic_done_w));         // R02 R11
	assign tick_w     = mon_f.sw_tick && !tick_d_q;                   // R14

	// ----------------------------------------------------------------
	// sequence state
	// ----------------------------------------------------------------
	// over-current wins over ramp completion so a short is never masked
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= bcs_pkg::ST_OFF;
		end else if (i_clk_en) begin
			case (state_q)
				bcs_pkg::ST_OFF: begin
					if (start_w) begin
						state_q <= bcs_pkg::ST_RAMP;                        // R02 R03
					end
				end
				bcs_pkg::ST_RAMP, bcs_pkg::ST_RUN: begin
					if (!por_w) begin
						state_q <= bcs_pkg::ST_OFF;                         // R01 R04 R12
					end else if (mon_f.oc) begin
						state_q <= bcs_pkg::ST_HICCUP;                      // R09 R11
					end else if (level_q == bcs_pkg::SS_TOP) begin
						state_q <= bcs_pkg::ST_RUN;
					end
				end
				bcs_pkg::ST_HICCUP: begin
					if (mon_f.ot) begin
						state_q <= bcs_pkg::ST_OFF;                         // R12
					end else if (hic_done_w) begin
						state_q <= start_w ? bcs_pkg::ST_RAMP : bcs_pkg::ST_OFF; // R11
					end
				end
				default: begin
					state_q <= bcs_pkg::ST_OFF;
				end
			endcase
		end
	end

	// hiccup blanking counter
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hic_q <= 24'h000000;
		end else if (i_clk_en) begin
			hic_q <= (state_q == bcs_pkg::ST_HICCUP && !hic_done_w) ? hic_q + 24'h000001
				: 24'h000000;                                              // R11
		end
	end

	// ----------------------------------------------------------------
	// soft-start ramp
	// ----------------------------------------------------------------
	// level drops in the same edge a fault is seen, not one later
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			level_q <= 12'h000;
			div_q   <= 8'h00;
		end else if (i_clk_en) begin
			if (!active_w) begin
				level_q <= 12'h000;                                         // R11 R12
				div_q   <= 8'h00;
			end else if (state_q == bcs_pkg::ST_RAMP) begin
				if (div_q == 8'(bcs_pkg::SS_STEP_CYC - 1)) begin
					div_q <= 8'h00;
					if (level_q != bcs_pkg::SS_TOP) begin
						level_q <= level_q + 12'h001;                       // R08
					end
				end else begin
					div_q <= div_q + 8'h01;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// switching period and pre-bias stepping
	// ----------------------------------------------------------------
	// period measured from the oscillator tick; phase count saturates if ticks stop
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tick_d_q <= 1'b0;
			phase_q  <= 16'h0000;
			period_q <= 16'h0000;
		end else if (i_clk_en) begin
			tick_d_q <= mon_f.sw_tick;
			if (tick_w) begin
				phase_q  <= 16'h0000;
				period_q <= phase_q + 16'h0001;
			end else if (phase_q != 16'hFFFF) begin
				phase_q <= phase_q + 16'h0001;
			end
		end
	end

	// step and pulse counters restart whenever the soft-start is reset
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pb_active_q <= 1'b0;
			pb_wait_q   <= 1'b0;
			step_q      <= bcs_pkg::PB_FIRST_STEP;
			pulse_q     <= 5'h00;
		end else if (i_clk_en) begin
			if (start_w) begin
				pb_active_q <= mon_f.prebias;
				pb_wait_q   <= mon_f.prebias;                               // R05
				step_q      <= bcs_pkg::PB_FIRST_STEP;                      // R06 R14
				pulse_q     <= 5'h00;
			end else if (!active_w) begin
				pb_active_q <= 1'b0;
				pb_wait_q   <= 1'b0;
				step_q      <= bcs_pkg::PB_FIRST_STEP;                      // R14
				pulse_q     <= 5'h00;
			end else if (pb_wait_q) begin
				pb_wait_q <= !mon_f.hs_pwm;                                 // R05
			end else if (pb_active_q && tick_w) begin
				if (pulse_q == bcs_pkg::PB_LAST_PULSE) begin
					pulse_q <= 5'h00;                                       // R07
					if (step_q == bcs_pkg::PB_LAST_STEP) begin
						pb_active_q <= 1'b0;
					end else begin
						step_q <= step_q + 4'h1;                            // R06
					end
				end else begin
					pulse_q <= pulse_q + 5'h01;                             // R07 R14
				end
			end
		end
	end

	// low-side window is step eighths of the measured period
	assign ls_prod_w = period_q * step_q;
	assign ls_lim_w  = ls_prod_w[18:3];                                   // R06
	// window closes the period, just before the next high pulse; phase_q
	// trails the tick by one cycle, hence the extra count
	assign ls_win_w  = (period_q != 16'h0000)
		&& (({1'b0, phase_q} + 17'h00001) >= {1'b0, period_q - ls_lim_w}); // R06

	// ----------------------------------------------------------------
	// driver and bias commands
	// ----------------------------------------------------------------
	// no dead time here; the gate drivers insert it
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_hs_on     <= 1'b0;
			o_ls_on     <= 1'b0;
			o_bias_high <= 1'b1;
			o_por_ready <= 1'b0;
		end else if (i_clk_en) begin
			o_hs_on     <= active_w && !mon_f.ov && mon_f.hs_pwm;         // R01 R04 R09
			o_ls_on     <= active_w && !pb_wait_q && !mon_f.hs_pwm
				&& (!pb_active_q || ls_win_w);                            // R05 R06
			o_bias_high <= !mon_f.light_load;                             // R10
			o_por_ready <= por_w;
		end
	end
	assign o_ss_level = level_q;

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	assign irq_ev_w[bcs_pkg::IRQ_OC] = active_w == 1'b0 && mon_f.oc && por_w
		&& (state_q == bcs_pkg::ST_RAMP || state_q == bcs_pkg::ST_RUN);
	assign irq_ev_w[bcs_pkg::IRQ_OT] = mon_f.ot && !ot_d_q;
	assign irq_ev_w[bcs_pkg::IRQ_OV] = mon_f.ov && !ov_d_q;
	assign irq_ev_w[bcs_pkg::IRQ_UP] = (state_q == bcs_pkg::ST_RAMP) && active_w
		&& (level_q == bcs_pkg::SS_TOP);
	assign irq_ev_w[bcs_pkg::IRQ_UV] = o_por_ready && !por_w;

	// a new event in the clearing read's cycle stays set
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ot_d_q     <= 1'b0;
			ov_d_q     <= 1'b0;
			irq_stat_q <= 5'h00;
			o_irq      <= 1'b0;
		end else if (i_clk_en) begin
			ot_d_q <= mon_f.ot;
			ov_d_q <= mon_f.ov;
			if (o_s_axi_arready && i_s_axi_arvalid && i_s_axi_araddr == bcs_pkg::REG_IRQ_STAT) begin
				irq_stat_q <= irq_ev_w;
			end else begin
				irq_stat_q <= irq_stat_q | irq_ev_w;
			end
			o_irq <= |(irq_stat_q & irq_mask_q);
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite slave
	// ----------------------------------------------------------------
	logic        aw_have_q;
	logic        w_have_q;
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic        w_strb0_q;
	logic        wr_go_w;
	logic        wr_hit_w;

	assign o_s_axi_awready = i_clk_en && !aw_have_q && !o_s_axi_bvalid;
	assign o_s_axi_wready  = i_clk_en && !w_have_q && !o_s_axi_bvalid;
	assign o_s_axi_arready = i_clk_en && !o_s_axi_rvalid;
	assign wr_go_w         = aw_have_q && w_have_q && !o_s_axi_bvalid;
	assign wr_hit_w        = (aw_addr_q == bcs_pkg::REG_CTRL) || (aw_addr_q == bcs_pkg::REG_IRQ_MASK);

	// address and data are taken in either order, response after both
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aw_have_q      <= 1'b0;
			w_have_q       <= 1'b0;
			aw_addr_q      <= 8'h00;
			w_data_q       <= 32'h00000000;
			w_strb0_q      <= 1'b0;
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp  <= bcs_pkg::RESP_OKAY;
			ctrl_en_q      <= bcs_pkg::CTRL_RST;
			irq_mask_q     <= bcs_pkg::MASK_RST;
		end else if (i_clk_en) begin
			if (o_s_axi_awready && i_s_axi_awvalid) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= i_s_axi_awaddr;
			end
			if (o_s_axi_wready && i_s_axi_wvalid) begin
				w_have_q  <= 1'b1;
				w_data_q  <= i_s_axi_wdata;
				w_strb0_q <= i_s_axi_wstrb[0];
			end
			if (wr_go_w) begin
				aw_have_q      <= 1'b0;
				w_have_q       <= 1'b0;
				o_s_axi_bvalid <= 1'b1;
				o_s_axi_bresp  <= wr_hit_w ? bcs_pkg::RESP_OKAY : bcs_pkg::RESP_SLVERR;
				if (w_strb0_q && aw_addr_q == bcs_pkg::REG_CTRL) begin
					ctrl_en_q <= w_data_q[bcs_pkg::CTRL_EN_BIT];
				end
				if (w_strb0_q && aw_addr_q == bcs_pkg::REG_IRQ_MASK) begin
					irq_mask_q <= w_data_q[bcs_pkg::IRQ_W-1:0];
				end
			end else if (o_s_axi_bvalid && i_s_axi_bready) begin
				o_s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read data captured at the address handshake
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata  <= 32'h00000000;
			o_s_axi_rresp  <= bcs_pkg::RESP_OKAY;
		end else if (i_clk_en) begin
			if (o_s_axi_arready && i_s_axi_arvalid) begin
				o_s_axi_rvalid <= 1'b1;
				o_s_axi_rresp  <= bcs_pkg::RESP_OKAY;
				case (i_s_axi_araddr)
					bcs_pkg::REG_CTRL:     o_s_axi_rdata <= {31'h00000000, ctrl_en_q};
					bcs_pkg::REG_STATUS:   o_s_axi_rdata <= {21'h000000, step_q, pb_wait_q,
						pb_active_q, o_por_ready, state_q};
					bcs_pkg::REG_IRQ_STAT: o_s_axi_rdata <= {27'h0000000, irq_stat_q};
					bcs_pkg::REG_IRQ_MASK: o_s_axi_rdata <= {27'h0000000, irq_mask_q};
					bcs_pkg::REG_LEVEL:    o_s_axi_rdata <= {20'h00000, level_q};
					default: begin
						o_s_axi_rdata <= 32'h00000000;
						o_s_axi_rresp <= bcs_pkg::RESP_SLVERR;
					end
				endcase
			end else if (o_s_axi_rvalid && i_s_axi_rready) begin
				o_s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	sequence hiccup_end_s;
		(state_q == bcs_pkg::ST_HICCUP) && hic_done_w && !mon_f.ot && i_clk_en;
	endsequence

	drv_off_undervoltage_lockout_a: assert property ((!(mon_f.vcc_ok && mon_f.en_ok) && i_clk_en) |=> // R01
		(!o_hs_on && !o_ls_on)) else $error("driver on while supply or enable low");
	por_start_a: assert property ((state_q == bcs_pkg::ST_OFF && por_w && ctrl_en_q // R02
		&& i_clk_en) |=> (state_q == bcs_pkg::ST_RAMP)) else $error("ramp did not start");
	en_gate_a: assert property ((state_q == bcs_pkg::ST_OFF && !mon_f.en_ok && i_clk_en) // R03
		|=> (state_q == bcs_pkg::ST_OFF)) else $error("started with enable low");
	shut_off_a: assert property ((!mon_f.en_ok && i_clk_en) |=> !o_hs_on ##0 !o_ls_on) // R04
		else $error("shutdown left a driver on");
	ls_wait_a: assert property ((pb_wait_q && i_clk_en) |=> !o_ls_on) // R05
		else $error("low side on before first high pulse");
	step_range_a: assert property (step_q >= bcs_pkg::PB_FIRST_STEP // R06
		&& step_q <= bcs_pkg::PB_LAST_STEP) else $error("duty step out of range");
	step_adv_a: assert property ((active_w && !start_w && !pb_wait_q && pb_active_q && tick_w // R07
		&& pulse_q == bcs_pkg::PB_LAST_PULSE && step_q != bcs_pkg::PB_LAST_STEP && i_clk_en)
		|=> (step_q == $past(step_q) + 4'h1 && pulse_q == 5'h00)) else $error("step not advanced");
	ramp_rate_a: assert property ((active_w && state_q == bcs_pkg::ST_RAMP && i_clk_en // R08
		&& div_q == 8'(bcs_pkg::SS_STEP_CYC - 1) && level_q != bcs_pkg::SS_TOP)
		|=> (level_q == $past(level_q) + 12'h001)) else $error("ramp step missed");
	oc_ramp_a: assert property ((state_q == bcs_pkg::ST_RAMP && por_w && mon_f.oc // R09
		&& i_clk_en) |=> (state_q == bcs_pkg::ST_HICCUP && level_q == 12'h000))
		else $error("over-current ignored during ramp");
	bias_sel_a: assert property (i_clk_en |=> (o_bias_high == !$past(mon_f.light_load))) // R10
		else $error("bias level wrong");
	hiccup_zero_a: assert property ((state_q == bcs_pkg::ST_HICCUP) |-> (level_q == 12'h000 // R11
		&& !o_hs_on || $past(state_q) != bcs_pkg::ST_HICCUP)) else $error("level up in hiccup");
	hiccup_retry_a: assert property (hiccup_end_s |=> (state_q != bcs_pkg::ST_HICCUP // R11
		&& hic_q == 24'h000000)) else $error("hiccup did not end");
	thermal_off_a: assert property ((mon_f.ot && i_clk_en) |=> (state_q == bcs_pkg::ST_OFF // R12
		&& level_q == 12'h000)) else $error("thermal did not stop");
	step_reset_a: assert property ((state_q == bcs_pkg::ST_OFF && i_clk_en) |=> // R14
		(step_q == bcs_pkg::PB_FIRST_STEP)) else $error("step not restarted");

endmodule // bcs_sequencer

// ---- rtl/bcs_pkg.sv ----
package bcs_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int          CLK_PERIOD_NS = 10;
	localparam int          SS_STEP_NS    = 1000;     // one level step per microsecond
	localparam int          SS_STEP_CYC   = (SS_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [11:0] SS_TOP        = 12'hEA6;  // 3750 steps of 0.4 mV is 1.5 V
	localparam int          HICCUP_NS     = 20480000; // 20.48 ms blanking
	localparam int          HICCUP_CYC    = HICCUP_NS / CLK_PERIOD_NS;
	localparam logic [3:0]  PB_FIRST_STEP = 4'h1;     // one eighth of a period
	localparam logic [3:0]  PB_LAST_STEP  = 4'h8;     // eight eighths
	localparam logic [4:0]  PB_LAST_PULSE = 5'h0F;    // sixteen pulses per step

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  REG_CTRL      = 8'h00;
	localparam logic [7:0]  REG_STATUS    = 8'h04;
	localparam logic [7:0]  REG_IRQ_STAT  = 8'h08;
	localparam logic [7:0]  REG_IRQ_MASK  = 8'h0C;
	localparam logic [7:0]  REG_LEVEL     = 8'h10;
	localparam logic        CTRL_RST      = 1'h1;     // sequencing enabled after reset
	localparam logic [4:0]  MASK_RST      = 5'h00;
	localparam int          CTRL_EN_BIT   = 0;
	localparam int          IRQ_OC        = 0;
	localparam int          IRQ_OT        = 1;
	localparam int          IRQ_OV        = 2;
	localparam int          IRQ_UP        = 3;
	localparam int          IRQ_UV        = 4;
	localparam int          IRQ_W         = 5;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_OFF    = 4'h1,
		ST_RAMP   = 4'h2,
		ST_RUN    = 4'h4,
		ST_HICCUP = 4'h8
	} bcs_state_t;

	// comparator and oscillator flags from the analog side
	typedef struct packed {
		logic vcc_ok;
		logic en_ok;
		logic oc;
		logic ov;
		logic ot;
		logic light_load;
		logic prebias;
		logic hs_pwm;
		logic sw_tick;
	} bcs_mon_t;

	typedef struct packed {
		logic [20:0] zero;
		logic [3:0]  step;
		logic        pb_wait;
		logic        pb_active;
		logic        por;
		bcs_state_t  state;
	} bcs_status_t;

endpackage

// ---- rtl/bcs_pin_sync.sv ----
`timescale 1ns/1ns

// three-stage pin synchroniser with agreement filter
module bcs_pin_sync #(
	parameter int W = 9
) (
	// clock and reset
	input  wire logic         i_ref_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_clk_en,
	// pins and filtered levels
	input  wire logic [W-1:0] i_pin,
	output logic      [W-1:0] o_level
);

	// ----------------------------------------------------------------
	// per bit stages
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			logic s1_q;
			logic s2_q;
			logic s3_q;
			logic lvl_q;
			// first stage only feeds the second, to keep metastability contained
			always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					s1_q  <= 1'b0;
					s2_q  <= 1'b0;
					s3_q  <= 1'b0;
					lvl_q <= 1'b0;
				end else if (i_clk_en) begin
					s1_q <= i_pin[g];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q) begin
						lvl_q <= s3_q;
					end
				end
			end
			assign o_level[g] = lvl_q;
		end
	endgenerate

endmodule // bcs_pin_sync

// ---- tb/bcs_analog_model.sv ----
`timescale 1ns/1ns

// analog side: comparator flags plus a switching oscillator
module bcs_analog_model #(
	parameter int PERIOD = 40,
	parameter int HS_CYC = 10
) (
	// clock and reset
	input  wire logic              i_ref_clk,
	input  wire logic              i_rst_n,
	// scenario controls
	input  wire logic              i_run,
	input  wire bcs_pkg::bcs_mon_t i_flags,
	// flags to the sequencer
	output bcs_pkg::bcs_mon_t      o_mon
);
	int	cnt_q;

	// oscillator stands still while switching is off
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= 0;
		end else begin
			cnt_q <= (i_run && cnt_q < PERIOD - 1) ? cnt_q + 1 : 0;
		end
	end

	// tick held 4 cycles so the agreement filter keeps it
	always_comb begin
		o_mon = i_flags;
		o_mon.hs_pwm = i_run && cnt_q < HS_CYC;
		o_mon.sw_tick = i_run && cnt_q < 4;
	end
endmodule // bcs_analog_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ns

module testbench;
	logic			clk = 1'b0;
	logic			rst_n = 1'b0;
	logic			run = 1'b0;
	logic			aw = 1'b0, w = 1'b0, ar = 1'b0, br = 1'b0, rr = 1'b0;
	logic [7:0]		aa = 8'h00, ra = 8'h00;
	logic [31:0]		wd = 32'h0, rd_v, rdata;
	logic			awr, wrdy, bv, arr, rv, hs, ls, bh, por, irq;
	logic [1:0]		bresp, rresp, rsp;
	logic [11:0]		lvl;
	bcs_pkg::bcs_mon_t	fl = '0, mon;
	int			failures = 0, num_checks = 0, nh, nl;

	bcs_analog_model bcs_analog_model_i (.i_ref_clk(clk), .i_rst_n(rst_n), .i_run(run),
		.i_flags(fl), .o_mon(mon));

	bcs_sequencer #(.HICCUP_CYC(50)) bcs_sequencer_i (.i_ref_clk(clk), .i_rst_n(rst_n),
		.i_clk_en(1'b1), .i_mon(mon), .i_s_axi_awvalid(aw), .o_s_axi_awready(awr),
		.i_s_axi_awaddr(aa), .i_s_axi_wvalid(w), .o_s_axi_wready(wrdy), .i_s_axi_wdata(wd),
		.i_s_axi_wstrb(4'hF), .o_s_axi_bvalid(bv), .i_s_axi_bready(br), .o_s_axi_bresp(bresp),
		.i_s_axi_arvalid(ar), .o_s_axi_arready(arr), .i_s_axi_araddr(ra), .o_s_axi_rvalid(rv),
		.i_s_axi_rready(rr), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_hs_on(hs),
		.o_ls_on(ls), .o_bias_high(bh), .o_por_ready(por), .o_ss_level(lvl), .o_irq(irq));

	// 100 MHz clock
	initial begin
		forever #5 clk = ~clk;
	end

	task automatic finish_test;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask

	// driver activity over k cycles
	task automatic sample(input int k);
		nh = 0;
		nl = 0;
		repeat (k) begin
			@(posedge clk);
			nh += (hs === 1'b1);
			nl += (ls === 1'b1);
		end
	endtask

	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		aw <= 1'b1;
		w <= 1'b1;
		aa <= a;
		wd <= d;
		br <= 1'b1;
		do begin
			@(posedge clk);
			if (awr) aw <= 1'b0;
			if (wrdy) w <= 1'b0;
		end while (bv !== 1'b1);
		rsp = bresp;
		br <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		ar <= 1'b1;
		ra <= a;
		rr <= 1'b1;
		do begin
			@(posedge clk);
			if (arr) ar <= 1'b0;
		end while (rv !== 1'b1);
		rd_v = rdata;
		rsp = rresp;
		rr <= 1'b0;
	endtask

	// state field of the status word
	task automatic st(input string nm, input logic [3:0] e);
		rd(bcs_pkg::REG_STATUS);
		chk(nm, rd_v[3:0], e);
	endtask

	// watchdog: whole run is a few thousand cycles
	initial begin
		#200000;
		failures++;
		finish_test;
	end

	initial begin
		cyc(2);
		rst_n <= 1'b1;
		cyc(2);
		chk("bias_rst", bh, 1'b1);
		chk("drv_rst", {hs, ls}, 2'h0);
		rd(bcs_pkg::REG_CTRL);
		chk("ctrl_rst", rd_v[0], bcs_pkg::CTRL_RST);
		wr(bcs_pkg::REG_IRQ_MASK, 32'h1 << bcs_pkg::IRQ_UV);
		fl.vcc_ok <= 1'b1;
		fl.prebias <= 1'b1;
		cyc(20);
		chk("por_no_en", por, 1'b0);
		fl.en_ok <= 1'b1;
		sample(30);
		chk("por_up", por, 1'b1);
		chk("pb_ls_off", nl + nh, 0);
		rd(bcs_pkg::REG_STATUS);
		chk("pb_wait", rd_v[6], 1'b1);
		run <= 1'b1;
		cyc(320);
		rd(bcs_pkg::REG_STATUS);
		chk("pb_step1", rd_v[10:5], {4'h1, 2'h1});
		sample(40);
		chk("hs_follow", nh, 10);
		chk("ls_eighth", nl, 5);
		cyc(440);
		rd(bcs_pkg::REG_STATUS);
		chk("pb_step2", rd_v[10:7], 4'h2);
		fl.en_ok <= 1'b0;
		cyc(10);
		chk("en_off_drv", {hs, ls, por}, 3'h0);
		chk("irq_uv", irq, 1'b1);
		rd(bcs_pkg::REG_IRQ_STAT);
		chk("stat_uv", rd_v[bcs_pkg::IRQ_UV], 1'b1);
		cyc(3);
		chk("irq_clr", irq, 1'b0);
		fl.prebias <= 1'b0;
		fl.en_ok <= 1'b1;
		while (por !== 1'b1) begin
			@(posedge clk);
		end
		cyc(2000);
		chk("ss_rate", lvl >= 12'h013 && lvl <= 12'h015, 1'b1);
		rd(bcs_pkg::REG_LEVEL);
		chk("level_rd", rd_v, 32'h14);
		st("ramp", bcs_pkg::ST_RAMP);
		fl.ov <= 1'b1;
		cyc(10);
		sample(40);
		chk("ov_hs", nh, 0);
		st("ov_ramp", bcs_pkg::ST_RAMP);
		fl.ov <= 1'b0;
		fl.oc <= 1'b1;
		cyc(10);
		fl.oc <= 1'b0;
		chk("oc_drv", {hs, ls, lvl}, 14'h0);
		st("hiccup", bcs_pkg::ST_HICCUP);
		cyc(60);
		st("retry", bcs_pkg::ST_RAMP);
		rd(bcs_pkg::REG_IRQ_STAT);
		chk("stat_oc_ov", rd_v, (32'h1 << bcs_pkg::IRQ_OC) | (32'h1 << bcs_pkg::IRQ_OV));
		fl.ot <= 1'b1;
		cyc(10);
		chk("ot_drv", {hs, ls}, 2'h0);
		st("ot_off", bcs_pkg::ST_OFF);
		wr(bcs_pkg::REG_CTRL, 32'h0);
		fl.ot <= 1'b0;
		cyc(10);
		st("ctrl_hold", bcs_pkg::ST_OFF);
		wr(bcs_pkg::REG_CTRL, 32'h1);
		st("ot_back", bcs_pkg::ST_RAMP);
		fl.light_load <= 1'b1;
		cyc(10);
		chk("bias_low", bh, 1'b0);
		fl.light_load <= 1'b0;
		cyc(10);
		chk("bias_high", bh, 1'b1);
		rd(8'h20);
		chk("unmap_rd", rd_v, 32'h0);
		chk("unmap_rresp", rsp, bcs_pkg::RESP_SLVERR);
		wr(8'h20, 32'h0);
		chk("unmap_wr", rsp, bcs_pkg::RESP_SLVERR);
		finish_test;
	end
endmodule // testbench
